/* design/ppf_pkg.sv */
// Summary of operation
// - Limit source picked by 4-bit selector: comparators, shared faults, independent two/four.
// - Limit polarity bit one means source is active low.
// - Limit input acts only while limit mode enable is set.
// - Fault source picked by separate selector using same codes.
// - Fault polarity bit one means source is active low.
// - Fault mode 00 forces fault override values, latched.
// - Fault mode 01 forces fault override values each cycle, unlatched.
// - Fault mode 11 ignores fault; code 10 reserved.
// - Thirteen-bit trigger value matched against time base yields trigger pulse.
// - Trigger value zero yields no trigger; software keeps it above minimum.
// - Edge-aligned timer counts up from zero toward period.
// - High output asserted while timer at or below duty value.
// - Timer above period resets and starts new cycle.
// - Pin-pair mode 00 drives low output as complement of high.
// - Push-pull alternates pulse between outputs each cycle, identical duty.
// - Pin-pair mode 10 selects push-pull.
// - Multi-phase adds phase shift to primary time base, output earlier.
// - Complementary and push-pull outputs never produced together by one generator.
// - Active limit truncates pulse, drives limit overrides until next cycle.
package ppf_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_FCL    = 8'h00;
  localparam logic [7:0] ADDR_TRIG   = 8'h04;
  localparam logic [7:0] ADDR_LEB    = 8'h08;
  localparam logic [7:0] ADDR_PER    = 8'h0C;
  localparam logic [7:0] ADDR_DUTY   = 8'h10;
  localparam logic [7:0] ADDR_PHASE  = 8'h14;
  localparam logic [7:0] ADDR_IOC    = 8'h18;
  localparam logic [7:0] ADDR_STAT   = 8'h1C;
  // Writable masks
  localparam logic [15:0] MASK_FCL   = 16'h1FFF;
  localparam logic [15:0] MASK_TRIG  = 16'hFFF8;
  localparam logic [15:0] MASK_LEB   = 16'hFFF8;
  localparam logic [15:0] MASK_PHASE = 16'hFFFC;
  localparam logic [15:0] MASK_IOC   = 16'h003F;
  localparam logic [15:0] RST_VAL    = 16'h0000;
  // Source codes
  localparam logic [3:0] SRC_CMP1 = 4'h0;
  localparam logic [3:0] SRC_CMP4 = 4'h3;
  localparam logic [3:0] SRC_SF1  = 4'h8;
  localparam logic [3:0] SRC_SF4  = 4'hB;
  localparam logic [3:0] SRC_IF2  = 4'hD;
  localparam logic [3:0] SRC_IF4  = 4'hF;
  // Fault modes
  localparam logic [1:0] FM_LATCH = 2'b00;
  localparam logic [1:0] FM_CYCLE = 2'b01;
  // Pin-pair modes
  localparam logic [1:0] PM_COMPL = 2'b00;
  localparam logic [1:0] PM_INDEP = 2'b01;
  localparam logic [1:0] PM_PUSH  = 2'b10;
  // Blanking: 8 ns step rounded up to 2 cycles (10 ns) at 5 ns clock
  localparam int BLANK_STEP_NS = 8;
  localparam int CLK_NS        = 5;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [2:0] rsv;
    logic [3:0] limit_source_select;
    logic       limit_polarity;
    logic       limit_mode_enable;
    logic [3:0] fault_source_select;
    logic       fault_polarity;
    logic [1:0] fault_mode;
  } ppf_fcl_s;

  typedef struct packed {
    logic       high_rise_blank_start;
    logic       high_fall_blank_start;
    logic       low_rise_blank_start;
    logic       low_fall_blank_start;
    logic       fault_blank_enable;
    logic       limit_blank_enable;
    logic [6:0] blank_duration;
    logic [2:0] rsv;
  } ppf_leb_s;

  typedef struct packed {
    logic [9:0] rsv;
    logic [1:0] fault_override_values;
    logic [1:0] limit_override_values;
    logic [1:0] pin_pair_mode;
  } ppf_ioc_s;
endpackage

/* design/ppf_top.sv */
`timescale 1ns/1ps
module ppf_top #(
  parameter int TW = 16
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Fault and limit sources (asynchronous)
  input  wire logic [3:0]  comparator_in,
  input  wire logic [3:0]  shared_fault_in,
  input  wire logic        independent_fault_two,
  input  wire logic        independent_fault_four,
  // Primary time base and multi-phase enable
  input  wire logic [TW-1:0] primary_time,
  input  wire logic        multi_phase_en,
  // Outputs
  output logic             high_output,
  output logic             low_output,
  output logic             trigger_pulse
);
  // Bus address phase capture
  logic       wr_q, wr_d;
  logic       rd_q, rd_d;
  logic [7:0] adr_q, adr_d;
  // Registers
  ppf_pkg::ppf_fcl_s fcl_q, fcl_d;
  ppf_pkg::ppf_leb_s leb_q, leb_d;
  ppf_pkg::ppf_ioc_s ioc_q, ioc_d;
  logic [15:0] trig_q, trig_d;
  logic [TW-1:0] per_q, per_d, duty_q, duty_d;
  logic [15:0] phase_q, phase_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rdy_q, err_q;
  // Synchronisers
  logic [9:0] s1_q, s2_q;
  // Generator state
  logic [TW-1:0] tmr_q, tmr_d;
  logic        swap_q, swap_d;
  logic        flatch_q, flatch_d;
  logic        clatch_q, clatch_d;
  logic [9:0]  blank_q, blank_d;
  logic        hi_q, hi_d, lo_q, lo_d, trg_q, trg_d;
  logic        hraw_q, lraw_q;
  // Combinational helpers
  logic        fault_raw, limit_raw, fault_act, limit_act, new_cyc, pulse;
  logic        h_gen, l_gen, hraw, lraw;
  logic [TW-1:0] tbase;

  function automatic logic pick(input logic [3:0] code, input logic [9:0] s);
    logic r;
    r = 1'b0;
    unique case (code)
      4'h0, 4'h1, 4'h2, 4'h3: r = s[code[1:0]];
      4'h8, 4'h9, 4'hA, 4'hB: r = s[4 + code[1:0]];
      ppf_pkg::SRC_IF2: r = s[8];
      ppf_pkg::SRC_IF4: r = s[9];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Input synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= 10'h000;
      s2_q <= 10'h000;
    end
    else
    begin
      s1_q <= {independent_fault_four, independent_fault_two, shared_fault_in, comparator_in};
      s2_q <= s1_q;
    end
  end

  // Bus and registers next state
  always_comb
  begin
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    adr_d   = adr_q;
    fcl_d   = fcl_q;
    leb_d   = leb_q;
    ioc_d   = ioc_q;
    trig_d  = trig_q;
    per_d   = per_q;
    duty_d  = duty_q;
    phase_d = phase_q;
    rdata_d = rdata_q;
    if (hsel && hready && htrans[1])
    begin
      wr_d  = hwrite;
      rd_d  = !hwrite;
      adr_d = haddr[7:0];
    end
    if (wr_q)
    begin
      unique case (adr_q)
        ppf_pkg::ADDR_FCL:   fcl_d   = hwdata[15:0] & ppf_pkg::MASK_FCL;
        ppf_pkg::ADDR_TRIG:  trig_d  = hwdata[15:0] & ppf_pkg::MASK_TRIG;
        ppf_pkg::ADDR_LEB:   leb_d   = hwdata[15:0] & ppf_pkg::MASK_LEB;
        ppf_pkg::ADDR_PER:   per_d   = hwdata[TW-1:0];
        ppf_pkg::ADDR_DUTY:  duty_d  = hwdata[TW-1:0];
        ppf_pkg::ADDR_PHASE: phase_d = hwdata[15:0] & ppf_pkg::MASK_PHASE;
        ppf_pkg::ADDR_IOC:   ioc_d   = hwdata[15:0] & ppf_pkg::MASK_IOC;
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        ppf_pkg::ADDR_FCL:   rdata_d = {16'h0000, fcl_q};
        ppf_pkg::ADDR_TRIG:  rdata_d = {16'h0000, trig_q};
        ppf_pkg::ADDR_LEB:   rdata_d = {16'h0000, leb_q};
        ppf_pkg::ADDR_PER:   rdata_d = 32'(per_q);
        ppf_pkg::ADDR_DUTY:  rdata_d = 32'(duty_q);
        ppf_pkg::ADDR_PHASE: rdata_d = {16'h0000, phase_q};
        ppf_pkg::ADDR_IOC:   rdata_d = {16'h0000, ioc_q};
        ppf_pkg::ADDR_STAT:  rdata_d = {26'h000_0000, clatch_q, flatch_q, swap_q,
                                        trg_q, lo_q, hi_q};
        default:             rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      adr_q   <= 8'h00;
      fcl_q   <= ppf_pkg::RST_VAL;
      leb_q   <= ppf_pkg::RST_VAL;
      ioc_q   <= ppf_pkg::RST_VAL;
      trig_q  <= ppf_pkg::RST_VAL;
      per_q   <= '0;
      duty_q  <= '0;
      phase_q <= ppf_pkg::RST_VAL;
      rdata_q <= 32'h0000_0000;
      rdy_q   <= 1'b1;
      err_q   <= 1'b0;
    end
    else
    begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      adr_q   <= adr_d;
      fcl_q   <= fcl_d;
      leb_q   <= leb_d;
      ioc_q   <= ioc_d;
      trig_q  <= trig_d;
      per_q   <= per_d;
      duty_q  <= duty_d;
      phase_q <= phase_d;
      rdata_q <= rdata_d;
      rdy_q   <= 1'b1;
      err_q   <= 1'b0;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = rdy_q;
  assign hresp     = err_q;

  // Generator next state
  always_comb
  begin
    // Source selection with polarity and blanking
    fault_raw = pick(fcl_q.fault_source_select, s2_q) ^ fcl_q.fault_polarity;
    limit_raw = pick(fcl_q.limit_source_select, s2_q) ^ fcl_q.limit_polarity;
    fault_act = fault_raw && (fcl_q.fault_mode != 2'b11) && (fcl_q.fault_mode != 2'b10)
                && !(leb_q.fault_blank_enable && blank_q != 10'h000);
    limit_act = limit_raw && fcl_q.limit_mode_enable
                && !(leb_q.limit_blank_enable && blank_q != 10'h000);
    // Time base
    new_cyc = (tmr_q > per_q);
    tmr_d   = new_cyc ? '0 : tmr_q + 1'b1;
    tbase   = multi_phase_en ? primary_time + phase_q[TW-1:0] : tmr_q;
    pulse   = (tbase <= duty_q);
    swap_d  = new_cyc ? !swap_q : swap_q;
    // Pin pair formatting, one mode at a time
    unique case (ioc_q.pin_pair_mode)
      ppf_pkg::PM_COMPL:
      begin
        h_gen = pulse;
        l_gen = !pulse;
      end
      ppf_pkg::PM_PUSH:
      begin
        h_gen = pulse && !swap_q;
        l_gen = pulse && swap_q;
      end
      default:
      begin
        h_gen = pulse;
        l_gen = 1'b0;
      end
    endcase
    // Latches
    flatch_d = (fcl_q.fault_mode == ppf_pkg::FM_LATCH) && (flatch_q || fault_act);
    clatch_d = new_cyc ? limit_act : (clatch_q || limit_act);
    // Override priority: fault, then limit
    hraw = h_gen;
    lraw = l_gen;
    if (flatch_d || (fault_act && fcl_q.fault_mode == ppf_pkg::FM_CYCLE))
    begin
      hraw = ioc_q.fault_override_values[1];
      lraw = ioc_q.fault_override_values[0];
    end
    else if (clatch_d)
    begin
      hraw = ioc_q.limit_override_values[1];
      lraw = ioc_q.limit_override_values[0];
    end
    hi_d = hraw;
    lo_d = lraw;
    // Blanking start on enabled edges
    blank_d = (blank_q != 10'h000) ? blank_q - 1'b1 : blank_q;
    if ((leb_q.high_rise_blank_start && hraw && !hraw_q) ||
        (leb_q.high_fall_blank_start && !hraw && hraw_q) ||
        (leb_q.low_rise_blank_start && lraw && !lraw_q) ||
        (leb_q.low_fall_blank_start && !lraw && lraw_q))
      blank_d = 10'(leb_q.blank_duration * ppf_pkg::BLANK_STEP_CYC);
    // Trigger compare, zero disabled
    trg_d = (trig_q[15:3] != 13'h0000) && (tmr_q == TW'(trig_q[15:3]));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tmr_q    <= '0;
      swap_q   <= 1'b0;
      flatch_q <= 1'b0;
      clatch_q <= 1'b0;
      blank_q  <= 10'h000;
      hi_q     <= 1'b0;
      lo_q     <= 1'b0;
      hraw_q   <= 1'b0;
      lraw_q   <= 1'b0;
      trg_q    <= 1'b0;
    end
    else
    begin
      tmr_q    <= tmr_d;
      swap_q   <= swap_d;
      flatch_q <= flatch_d;
      clatch_q <= clatch_d;
      blank_q  <= blank_d;
      hi_q     <= hi_d;
      lo_q     <= lo_d;
      hraw_q   <= hraw;
      lraw_q   <= lraw;
      trg_q    <= trg_d;
    end
  end

  assign high_output   = hi_q;
  assign low_output    = lo_q;
  assign trigger_pulse = trg_q;

  // Trigger and time base checks
  AST_TRIG_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (trig_q[15:3] == 13'h0000) |=> !trigger_pulse) else $error("Trigger with zero compare");
  AST_TRIG_MATCH: assert property (@(posedge hclk) disable iff (!hresetn)
    (trig_q[15:3] != 13'h0000 && tmr_q == TW'(trig_q[15:3])) |=> trigger_pulse)
    else $error("Missed trigger on match");
  AST_TMR_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (tmr_q > per_q) |=> (tmr_q == '0)) else $error("Timer not reset past period");
  AST_TMR_UP: assert property (@(posedge hclk) disable iff (!hresetn)
    (tmr_q <= per_q) |=> (tmr_q == $past(tmr_q) + 1'b1)) else $error("Timer not counting");
  AST_HI_DUTY: assert property (@(posedge hclk) disable iff (!hresetn)
    (ioc_q.pin_pair_mode != ppf_pkg::PM_PUSH && !multi_phase_en && !flatch_d && !fault_act
     && !clatch_d && tmr_q <= duty_q) |=> high_output) else $error("High missing in duty");
  AST_LO_DUTY: assert property (@(posedge hclk) disable iff (!hresetn)
    (ioc_q.pin_pair_mode != ppf_pkg::PM_PUSH && !multi_phase_en && !flatch_d && !fault_act
     && !clatch_d && tmr_q > duty_q) |=> !high_output) else $error("High past duty");

  // Pin pair checks
  AST_COMPL: assert property (@(posedge hclk) disable iff (!hresetn)
    (ioc_q.pin_pair_mode == ppf_pkg::PM_COMPL && !flatch_d && !fault_act && !clatch_d)
    |=> (low_output == !high_output)) else $error("Low not complement");
  AST_PUSH_EXCL: assert property (@(posedge hclk) disable iff (!hresetn)
    (ioc_q.pin_pair_mode == ppf_pkg::PM_PUSH && !flatch_d && !fault_act && !clatch_d)
    |=> !(high_output && low_output)) else $error("Push-pull both high");
  AST_PUSH_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
    (ioc_q.pin_pair_mode == ppf_pkg::PM_PUSH && !swap_q && !flatch_d && !fault_act && !clatch_d)
    |=> !low_output) else $error("Push-pull low in high phase");
  AST_PUSH_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (ioc_q.pin_pair_mode == ppf_pkg::PM_PUSH && swap_q && !flatch_d && !fault_act && !clatch_d)
    |=> !high_output) else $error("Push-pull high in low phase");
  AST_INDEP_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (ioc_q.pin_pair_mode == ppf_pkg::PM_INDEP && !flatch_d && !fault_act && !clatch_d)
    |=> !low_output) else $error("Independent low driven");

  // Fault and limit checks
  AST_FLT_OVR: assert property (@(posedge hclk) disable iff (!hresetn)
    (flatch_d || (fault_act && fcl_q.fault_mode == ppf_pkg::FM_CYCLE))
    |=> ({high_output, low_output} == $past(ioc_q.fault_override_values)))
    else $error("Fault override not driven");
  AST_CL_OVR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clatch_d && !flatch_d && !(fault_act && fcl_q.fault_mode == ppf_pkg::FM_CYCLE))
    |=> ({high_output, low_output} == $past(ioc_q.limit_override_values)))
    else $error("Limit override not driven");
  AST_FLT_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
    (flatch_q && fcl_q.fault_mode == ppf_pkg::FM_LATCH) |=> flatch_q)
    else $error("Latched fault lost");
  AST_FLT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (fcl_q.fault_mode == 2'b11) |-> !fault_act) else $error("Disabled fault acted");
  AST_FLT_RSV: assert property (@(posedge hclk) disable iff (!hresetn)
    (fcl_q.fault_mode == 2'b10) |-> !fault_act) else $error("Reserved fault mode acted");
  AST_CL_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    !fcl_q.limit_mode_enable |-> !limit_act) else $error("Limit acted while off");
  AST_CL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (clatch_q && !new_cyc) |=> clatch_q) else $error("Limit released mid cycle");
  AST_CL_NEWCYC: assert property (@(posedge hclk) disable iff (!hresetn)
    (new_cyc && !limit_act) |=> !clatch_q) else $error("Limit kept past new cycle");

  // Blanking and bus checks
  AST_BLANK: assert property (@(posedge hclk) disable iff (!hresetn)
    (blank_q != 10'h000 && leb_q.fault_blank_enable) |-> !fault_act)
    else $error("Fault seen while blanked");
  AST_BLANK_CL: assert property (@(posedge hclk) disable iff (!hresetn)
    (blank_q != 10'h000 && leb_q.limit_blank_enable && new_cyc) |=> !clatch_q)
    else $error("Limit seen while blanked");
  AST_BLANK_START: assert property (@(posedge hclk) disable iff (!hresetn)
    (leb_q.blank_duration != 7'h00 && ((leb_q.high_rise_blank_start && hraw && !hraw_q)
     || (leb_q.high_fall_blank_start && !hraw && hraw_q) || (leb_q.low_rise_blank_start
     && lraw && !lraw_q) || (leb_q.low_fall_blank_start && !lraw && lraw_q)))
    |=> (blank_q != 10'h000)) else $error("Blanking not started on edge");
  AST_RDATA_RSV: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_q |-> (hrdata[31:16] == 16'h0000)) else $error("Upper read bits not zero");
endmodule // ppf_top

/* test/ppf_partner.sv */
`timescale 1ns/1ps
module ppf_partner (
  // Line levels from the bench, comparators first
  input  wire logic [9:0] lines,
  // Sources into the generator
  output logic [3:0]      comparator_in,
  output logic [3:0]      shared_fault_in,
  output logic            independent_fault_two,
  output logic            independent_fault_four
);
  // Comparators, shared faults, then the two independent faults
  assign comparator_in          = lines[3:0];
  assign shared_fault_in        = lines[7:4];
  assign independent_fault_two  = lines[8];
  assign independent_fault_four = lines[9];
endmodule // ppf_partner

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [9:0]  lines;
  logic [3:0]  cmp;
  logic [3:0]  sfl;
  logic        if2;
  logic        if4;
  logic [15:0] ptime;
  logic        mph;
  logic        hi;
  logic        lo;
  logic        trg;
  logic [31:0] rd;
  int          n_fail;
  int          num_checks;
  int          cyc = 0;
  int          c [4];
  int          eh [3] = '{20, 20, 10};
  int          el [3] = '{28, 0, 10};
  logic [3:0]  codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hF};
  logic [7:0]  ra [6] = '{ppf_pkg::ADDR_FCL, ppf_pkg::ADDR_TRIG, ppf_pkg::ADDR_LEB,
                          ppf_pkg::ADDR_PHASE, ppf_pkg::ADDR_IOC, 8'h20};
  logic [15:0] rm [6] = '{ppf_pkg::MASK_FCL, ppf_pkg::MASK_TRIG, ppf_pkg::MASK_LEB,
                          ppf_pkg::MASK_PHASE, ppf_pkg::MASK_IOC, 16'h0000};

  ppf_top #(.TW(16)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comparator_in(cmp),
    .shared_fault_in(sfl), .independent_fault_two(if2), .independent_fault_four(if4),
    .primary_time(ptime), .multi_phase_en(mph), .high_output(hi), .low_output(lo),
    .trigger_pulse(trg)
  );

  ppf_partner u_far (
    .lines(lines), .comparator_in(cmp), .shared_fault_in(sfl),
    .independent_fault_two(if2), .independent_fault_four(if4)
  );

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t pins got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      n_fail++;
      $display("ERROR %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // Count high, low, trigger and both-high cycles at settled points
  task automatic cnt(input int n);
    c = '{0, 0, 0, 0};
    repeat (n)
    begin
      @(negedge hclk);
      c[0] += int'(hi === 1'b1);
      c[1] += int'(lo === 1'b1);
      c[2] += int'(trg === 1'b1);
      c[3] += int'(hi === 1'b1 && lo === 1'b1);
    end
  endtask

  // Selected line active or idle, every other line opposite
  task automatic setl(input int i, input logic act, input logic pol);
    @(posedge hclk);
    lines <= (act ? (10'h001 << i) : ~(10'h001 << i)) ^ {10{pol}};
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0000_0000;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0000_0000;
    lines   = 10'h000;
    ptime   = 16'h0000;
    mph     = 1'b0;
    n_fail  = 0;
    num_checks = 0;
    waitc(10);
    hresetn <= 1'b1;
    // Reset values, writable bits, unmapped place
    for (int r = 0; r < 6; r++)
    begin
      bus(1'b0, ra[r], 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b1, ra[r], 32'hFFFF_FFFF);
      bus(1'b0, ra[r], 32'h0000_0000);
      chk(rd, {16'h0000, rm[r]});
      bus(1'b1, ra[r], 32'h0000_0000);
    end
    // Output modes and trigger
    bus(1'b1, ppf_pkg::ADDR_FCL, 32'h0000_0003);
    bus(1'b1, ppf_pkg::ADDR_PER, 32'h0000_000A);
    bus(1'b1, ppf_pkg::ADDR_DUTY, 32'h0000_0004);
    bus(1'b1, ppf_pkg::ADDR_TRIG, 32'h0000_0028);
    for (int m = 0; m < 3; m++)
    begin
      bus(1'b1, ppf_pkg::ADDR_IOC, 32'h0000_003C | m);
      waitc(30);
      cnt(48);
      chkn(c[0], eh[m]);
      chkn(c[1], el[m]);
      chkn(c[2], 4);
      chkn(c[3], 0);
    end
    bus(1'b1, ppf_pkg::ADDR_IOC, 32'h0000_003C);
    bus(1'b1, ppf_pkg::ADDR_TRIG, 32'h0000_0040);
    waitc(2);
    cnt(48);
    chkn(c[2], 4);
    bus(1'b1, ppf_pkg::ADDR_TRIG, 32'h0000_0000);
    waitc(2);
    cnt(48);
    chkn(c[2], 0);
    // Shifted primary time base
    @(posedge hclk);
    mph <= 1'b1;
    bus(1'b1, ppf_pkg::ADDR_PHASE, 32'h0000_0000);
    waitc(10);
    @(negedge hclk);
    chkp({hi, lo}, 2'b10);
    bus(1'b1, ppf_pkg::ADDR_PHASE, 32'h0000_0014);
    waitc(10);
    @(negedge hclk);
    chkp({hi, lo}, 2'b01);
    @(posedge hclk);
    mph <= 1'b0;
    // Every source code and polarity, fault then limit
    for (int l = 0; l < 2; l++)
      for (int i = 0; i < 10; i++)
        for (int p = 0; p < 2; p++)
        begin
          setl(i, 1'b0, p[0]);
          bus(1'b1, ppf_pkg::ADDR_FCL, l ? {19'h0_0000, codes[i], p[0], 1'b1, 7'h03}
                                         : {25'h000_0000, codes[i], p[0], 2'b01});
          waitc(30);
          cnt(24);
          chkn(c[3], 0);
          setl(i, 1'b1, p[0]);
          waitc(8);
          cnt(24);
          chkn(c[3], 24);
        end
    // Limit disabled and fault ignored
    bus(1'b1, ppf_pkg::ADDR_FCL, 32'h0000_0003);
    setl(0, 1'b1, 1'b0);
    waitc(30);
    cnt(24);
    chkn(c[3], 0);
    bus(1'b1, ppf_pkg::ADDR_FCL, 32'h0000_0002);
    waitc(30);
    cnt(24);
    chkn(c[3], 0);
    // Latched fault outlives its source
    bus(1'b1, ppf_pkg::ADDR_FCL, 32'h0000_0000);
    waitc(8);
    setl(0, 1'b0, 1'b0);
    waitc(30);
    cnt(24);
    chkn(c[3], 24);
    bus(1'b0, ppf_pkg::ADDR_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0033, 32'h0000_0013);
    bus(1'b1, ppf_pkg::ADDR_FCL, 32'h0000_0001);
    waitc(30);
    cnt(24);
    chkn(c[3], 0);
    // Blanking started by each enabled edge in turn
    for (int e = 0; e < 4; e++)
    begin
      setl(0, 1'b0, 1'b0);
      bus(1'b1, ppf_pkg::ADDR_LEB, 32'h0000_0BF8 | (32'h0000_8000 >> e));
      waitc(30);
      setl(0, 1'b1, 1'b0);
      waitc(8);
      cnt(24);
      chkn(c[3], 0);
    end
    bus(1'b1, ppf_pkg::ADDR_LEB, 32'h0000_0BF8);
    waitc(300);
    cnt(24);
    chkn(c[3], 24);
    // Limit blanking, then limit override and its status
    setl(0, 1'b0, 1'b0);
    bus(1'b1, ppf_pkg::ADDR_FCL, 32'h0000_0083);
    bus(1'b1, ppf_pkg::ADDR_LEB, 32'h0000_87F8);
    waitc(30);
    setl(0, 1'b1, 1'b0);
    waitc(8);
    cnt(24);
    chkn(c[3], 0);
    bus(1'b1, ppf_pkg::ADDR_LEB, 32'h0000_07F8);
    waitc(300);
    cnt(24);
    chkn(c[3], 24);
    bus(1'b0, ppf_pkg::ADDR_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0033, 32'h0000_0023);
    report_and_stop;
  end
endmodule // tb
